// File: rtl/dtp_pkg.sv
// shared constants and carrier types for the dual 8-bit timer pair
// assumes: one 10 MHz clock, AXI4-Lite register access, external prescaler
package dtp_pkg;

  // ---------------------------------------------------------------
  // bus geometry
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned TW = 8;
  localparam int unsigned IDX_W = 6;

  // register indexes; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_RUN = 6'h20;
  localparam logic [IDX_W-1:0] IDX_TOGGLE = 6'h24;
  localparam logic [IDX_W-1:0] IDX_LCMP = 6'h26;
  localparam logic [IDX_W-1:0] IDX_UCMP = 6'h27;
  localparam logic [IDX_W-1:0] IDX_MODE = 6'h28;
  localparam logic [IDX_W-1:0] IDX_BUF = 6'h29;
  localparam logic [IDX_W-1:0] IDX_STAT = 6'h2A;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned MODE_LSB = 6;
  localparam int unsigned PWM_LSB = 4;
  localparam int unsigned UCLK_LSB = 2;
  localparam int unsigned LCLK_LSB = 0;
  localparam int unsigned RUN_LOWER_BIT = 2;
  localparam int unsigned RUN_UPPER_BIT = 3;
  localparam int unsigned BUF_EN_BIT = 1;
  localparam int unsigned TOG_CMD_LSB = 0;
  localparam int unsigned TOG_SEL_BIT = 2;
  localparam int unsigned TOG_EN_BIT = 3;
  localparam int unsigned STAT_UCNT_LSB = 8;
  localparam int unsigned STAT_TFF_BIT = 16;
  localparam int unsigned STAT_HOLD_BIT = 17;

  // ---------------------------------------------------------------
  // encodings
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_TWO8 = 2'b00,
    MODE_CASC16 = 2'b01,
    MODE_PPG = 2'b10,
    MODE_PWM = 2'b11
  } dtp_mode_e;

  localparam logic [1:0] LCLK_FINE = 2'b01;
  localparam logic [1:0] LCLK_QUARTER = 2'b10;
  localparam logic [1:0] LCLK_SIXTEENTH = 2'b11;
  localparam logic [1:0] UCLK_MATCH = 2'b00;
  localparam logic [1:0] UCLK_FINE = 2'b01;
  localparam logic [1:0] UCLK_SIXTEENTH = 2'b10;
  localparam logic [1:0] PWM_CODE_N6 = 2'b01;
  localparam logic [1:0] PWM_CODE_N7 = 2'b10;
  localparam logic [TW-1:0] PWM_TOP_N6 = 8'h3F;
  localparam logic [TW-1:0] PWM_TOP_N7 = 8'h7F;
  localparam logic [TW-1:0] PWM_TOP_N8 = 8'hFF;
  localparam logic [1:0] TCMD_INVERT = 2'b00;
  localparam logic [1:0] TCMD_CLEAR = 2'b01;
  localparam logic [1:0] TCMD_SET = 2'b10;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [TW-1:0] MODE_RST = 8'h00;
  localparam logic [TW-1:0] CMP_RST = 8'h00;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic [2:0] awprot;
    logic awvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [ADDR_W-1:0] araddr;
    logic [2:0] arprot;
    logic arvalid;
    logic rready;
  } dtp_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } dtp_axi_rsp_s;

  typedef struct packed {
    logic fine;
    logic quarter;
    logic sixteenth;
    logic coarse;
  } dtp_taps_s;

  typedef struct packed {
    dtp_axi_rsp_s rsp;
    logic aw_got;
    logic w_got;
    logic [IDX_W-1:0] widx;
    logic [TW-1:0] wbyte;
    logic wlane;
    logic [TW-1:0] mode_reg;
    logic buf_en;
    logic run_lower;
    logic run_upper;
    logic tog_sel;
    logic tog_en;
    logic [TW-1:0] lcmp;
    logic [TW-1:0] ucmp;
    logic [TW-1:0] lbuf;
    logic cmp_hold;
    logic tff;
    logic irq_lower;
    logic irq_upper;
  } dtp_state_s;

endpackage : dtp_pkg

// File: rtl/dtp_up_counter.sv
// one up counter of the timer pair, advancing on a one-cycle tick
// assumes: tick, run and clear come from logic on the same clock
`timescale 1ns/10ps
module dtp_up_counter #(
  parameter int unsigned W = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic run,
  input wire logic tick,
  input wire logic clear,
  // state
  output logic [W-1:0] count_ff
);

  if (W < 2) begin : g_bad_width
    $error("dtp_up_counter: width must be at least 2");
  end

  logic [W-1:0] nxt_count;

  // ---------------------------------------------------------------
  // next count
  // ---------------------------------------------------------------
  always_comb begin
    nxt_count = count_ff;
    if (!run || clear) begin
      nxt_count = '0;
    end else if (tick) begin
      nxt_count = W'(count_ff + 1'b1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_ff <= '0;
    end else begin
      count_ff <= nxt_count;
    end
  end

endmodule : dtp_up_counter

// File: rtl/dtp_timer_pair.sv
// dual 8-bit timer pair: interval, cascaded 16-bit, pulse and PWM modes
// assumes: AXI4-Lite master on aclk, prescaler taps are one-cycle pulses
// on aclk, pin sharing with the port bit is done outside this block
//
// How it works
// RL1: mode field picks two 8-bit, cascaded 16-bit, pulse or PWM mode.
// RL2: PWM period code 01/10/11 gives 63, 127 or 255 lower ticks.
// RL3: lower clock from fine/quarter/sixteenth taps; upper from lower match, fine, sixteenth or coarse.
// RL4: cascaded mode steps upper counter on lower overflow, ignoring select.
// RL5: lower compare write holds comparator until upper compare is written.
// RL6: cascaded lower match neither clears lower counter nor interrupts.
// RL7: cascaded joint match clears both, upper interrupt, optional toggle.
// RL8: pulse mode toggles output at lower and upper compare matches.
// RL9: software keeps lower compare below upper compare in pulse mode.
// RL10: software sets upper run bit in pulse mode.
// RL11: pulse mode with buffer loads lower compare at period match.
// RL12: PWM toggles at compare and at 2^n-1, clearing lower counter there.
// RL13: software keeps PWM compare nonzero and below 2^n-1.
// RL14: PWM with buffer loads lower compare at the 2^n-1 point.
// RL15: PWM uses only lower timer; upper stays an interval timer.
// RL16: pulse and PWM waveforms drive the toggle output pin.
// RL17: buffer enable bit resets to 0; its lowest bit reads zero.
// RL18: toggle command field always reads back as ones.
// RL19: two-8-bit mode runs each timer with its own periodic interrupt.
// RL20: toggle flop inverts on each selected match for square output.
// RL21: interval match clears counter, interrupts, optionally toggles.
// RL22: compare value zero matches on counter overflow.
// RL23: run bit counts when set, stops and clears when cleared.
// RL24: buffer off writes buffer and compare; buffer on writes buffer only.
// RL25: counters step once per selected tick, all on the system clock.
`timescale 1ns/10ps
module dtp_timer_pair (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire dtp_pkg::dtp_axi_req_s axi_req,
  output dtp_pkg::dtp_axi_rsp_s axi_rsp,
  // prescaler taps
  input wire dtp_pkg::dtp_taps_s taps,
  // timer outputs
  output logic toggle_output_pin,
  output logic lower_match_irq,
  output logic upper_match_irq
);

  dtp_pkg::dtp_state_s s_ff;
  dtp_pkg::dtp_state_s nxt_s;

  logic [dtp_pkg::TW-1:0] lower_up_counter;
  logic [dtp_pkg::TW-1:0] upper_up_counter;
  logic [dtp_pkg::TW-1:0] lower_nxt;
  logic [dtp_pkg::TW-1:0] upper_nxt;
  logic [dtp_pkg::TW-1:0] pwm_top;
  logic [1:0] lower_clock_select;
  logic [1:0] upper_clock_select;
  logic [1:0] pwm_cycle_select;
  dtp_pkg::dtp_mode_e pair_mode_field;
  logic lower_tick;
  logic upper_tick;
  logic lower_hit;
  logic lower_at_upper;
  logic pwm_wrap;
  logic lower_ovf;
  logic upper_hit;
  logic joint_hit;
  logic lower_clear;
  logic upper_clear;
  logic lower_irq_ev;
  logic upper_irq_ev;
  logic invert_ev;
  logic buf_load;
  logic do_write;
  logic [dtp_pkg::IDX_W-1:0] ridx;
  logic [dtp_pkg::DATA_W-1:0] rd_word;
  logic rd_ok;

  // ---------------------------------------------------------------
  // counters
  // ---------------------------------------------------------------
  dtp_up_counter #(.W(dtp_pkg::TW)) u_lower (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(s_ff.run_lower),
    .tick(lower_tick),
    .clear(lower_clear),
    .count_ff(lower_up_counter)
  );

  dtp_up_counter #(.W(dtp_pkg::TW)) u_upper (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(s_ff.run_upper),
    .tick(upper_tick),
    .clear(upper_clear),
    .count_ff(upper_up_counter)
  );

  // ---------------------------------------------------------------
  // clock selection and comparators
  // ---------------------------------------------------------------
  always_comb begin
    pair_mode_field = dtp_pkg::dtp_mode_e'(
      s_ff.mode_reg[dtp_pkg::MODE_LSB +: 2]);                       // [RL1]
    pwm_cycle_select = s_ff.mode_reg[dtp_pkg::PWM_LSB +: 2];
    upper_clock_select = s_ff.mode_reg[dtp_pkg::UCLK_LSB +: 2];
    lower_clock_select = s_ff.mode_reg[dtp_pkg::LCLK_LSB +: 2];
    // code 00 of the lower select gives no tick at all
    case (lower_clock_select)
      dtp_pkg::LCLK_FINE: lower_tick = taps.fine;                   // [RL3]
      dtp_pkg::LCLK_QUARTER: lower_tick = taps.quarter;
      dtp_pkg::LCLK_SIXTEENTH: lower_tick = taps.sixteenth;
      default: lower_tick = 1'b0;
    endcase
    // a stopped timer must not match on its held zero count
    lower_tick = lower_tick && s_ff.run_lower;                      // [RL23]
    case (pwm_cycle_select)
      dtp_pkg::PWM_CODE_N6: pwm_top = dtp_pkg::PWM_TOP_N6;          // [RL2]
      dtp_pkg::PWM_CODE_N7: pwm_top = dtp_pkg::PWM_TOP_N7;
      default: pwm_top = dtp_pkg::PWM_TOP_N8;
    endcase
    // matching on the incremented value makes a zero compare hit at wrap
    lower_nxt = dtp_pkg::TW'(lower_up_counter + 1'b1);              // [RL25]
    lower_hit = lower_tick && (lower_nxt == s_ff.lcmp);             // [RL22]
    lower_at_upper = lower_tick && (lower_nxt == s_ff.ucmp);
    pwm_wrap = lower_tick && (lower_nxt == pwm_top);
    lower_ovf = lower_tick && (lower_up_counter == dtp_pkg::PWM_TOP_N8);
    joint_hit = lower_hit && (upper_up_counter == s_ff.ucmp)
                && !s_ff.cmp_hold;                                  // [RL5]
    if (pair_mode_field == dtp_pkg::MODE_CASC16) begin
      upper_tick = lower_ovf;                                       // [RL4]
    end else begin
      case (upper_clock_select)
        dtp_pkg::UCLK_MATCH: upper_tick = lower_hit;                // [RL3]
        dtp_pkg::UCLK_FINE: upper_tick = taps.fine;
        dtp_pkg::UCLK_SIXTEENTH: upper_tick = taps.sixteenth;
        default: upper_tick = taps.coarse;
      endcase
    end
    upper_tick = upper_tick && s_ff.run_upper;                      // [RL23]
    upper_nxt = dtp_pkg::TW'(upper_up_counter + 1'b1);
    upper_hit = upper_tick && (upper_nxt == s_ff.ucmp);
  end

  // ---------------------------------------------------------------
  // per-mode event routing
  // ---------------------------------------------------------------
  always_comb begin
    lower_clear = 1'b0;
    upper_clear = 1'b0;
    lower_irq_ev = 1'b0;
    upper_irq_ev = 1'b0;
    invert_ev = 1'b0;
    buf_load = 1'b0;
    case (pair_mode_field)
      dtp_pkg::MODE_TWO8: begin
        lower_clear = lower_hit;                                    // [RL21]
        lower_irq_ev = lower_hit;                                   // [RL19]
        upper_clear = upper_hit;
        upper_irq_ev = upper_hit;
        invert_ev = s_ff.tog_en
                    && (s_ff.tog_sel ? upper_hit : lower_hit);      // [RL20]
      end
      dtp_pkg::MODE_CASC16: begin
        // a lone lower match clears nothing and raises nothing
        lower_clear = joint_hit;                                    // [RL6]
        upper_clear = joint_hit;                                    // [RL7]
        upper_irq_ev = joint_hit;
        invert_ev = s_ff.tog_en && joint_hit;
      end
      dtp_pkg::MODE_PPG: begin
        // upper counter is unused here and held at zero
        lower_clear = lower_at_upper;
        lower_irq_ev = lower_at_upper;
        upper_clear = 1'b1;
        invert_ev = s_ff.tog_en && (lower_hit || lower_at_upper);  // [RL8]
        buf_load = s_ff.buf_en && lower_at_upper;                   // [RL11]
      end
      dtp_pkg::MODE_PWM: begin
        lower_clear = pwm_wrap;                                     // [RL12]
        lower_irq_ev = pwm_wrap;
        invert_ev = s_ff.tog_en && (lower_hit || pwm_wrap);
        buf_load = s_ff.buf_en && pwm_wrap;                         // [RL14]
        upper_clear = upper_hit;                                    // [RL15]
        upper_irq_ev = upper_hit;
      end
      default: begin
        lower_clear = 1'b1;
        upper_clear = 1'b1;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // register read mux
  // ---------------------------------------------------------------
  always_comb begin
    ridx = axi_req.araddr[dtp_pkg::ADDR_W-1:2];
    rd_word = '0;
    rd_ok = 1'b1;
    case (ridx)
      dtp_pkg::IDX_RUN: begin
        rd_word[dtp_pkg::RUN_LOWER_BIT] = s_ff.run_lower;
        rd_word[dtp_pkg::RUN_UPPER_BIT] = s_ff.run_upper;
      end
      dtp_pkg::IDX_TOGGLE: begin
        rd_word[dtp_pkg::TOG_CMD_LSB +: 2] = 2'b11;                 // [RL18]
        rd_word[dtp_pkg::TOG_SEL_BIT] = s_ff.tog_sel;
        rd_word[dtp_pkg::TOG_EN_BIT] = s_ff.tog_en;
      end
      dtp_pkg::IDX_LCMP: rd_word = '0;
      dtp_pkg::IDX_UCMP: rd_word = '0;
      dtp_pkg::IDX_MODE: rd_word[dtp_pkg::TW-1:0] = s_ff.mode_reg;
      dtp_pkg::IDX_BUF: rd_word[dtp_pkg::BUF_EN_BIT] = s_ff.buf_en; // [RL17]
      dtp_pkg::IDX_STAT: begin
        rd_word[dtp_pkg::TW-1:0] = lower_up_counter;
        rd_word[dtp_pkg::STAT_UCNT_LSB +: dtp_pkg::TW] = upper_up_counter;
        rd_word[dtp_pkg::STAT_TFF_BIT] = s_ff.tff;
        rd_word[dtp_pkg::STAT_HOLD_BIT] = s_ff.cmp_hold;
      end
      default: rd_ok = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // bus slave and register state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    do_write = s_ff.aw_got && s_ff.w_got && !s_ff.rsp.bvalid;
    // address and data may come in either order
    if (s_ff.rsp.awready && axi_req.awvalid) begin
      nxt_s.aw_got = 1'b1;
      nxt_s.widx = axi_req.awaddr[dtp_pkg::ADDR_W-1:2];
    end
    if (s_ff.rsp.wready && axi_req.wvalid) begin
      nxt_s.w_got = 1'b1;
      nxt_s.wbyte = axi_req.wdata[dtp_pkg::TW-1:0];
      nxt_s.wlane = axi_req.wstrb[0];
    end
    if (s_ff.rsp.bvalid && axi_req.bready) begin
      nxt_s.rsp.bvalid = 1'b0;
    end
    // hardware events first so a software write in the same cycle wins
    if (buf_load) begin
      nxt_s.lcmp = s_ff.lbuf;
    end
    if (invert_ev) begin
      nxt_s.tff = !s_ff.tff;                                        // [RL16]
    end
    nxt_s.irq_lower = lower_irq_ev;
    nxt_s.irq_upper = upper_irq_ev;
    if (do_write) begin
      nxt_s.aw_got = 1'b0;
      nxt_s.w_got = 1'b0;
      nxt_s.rsp.bvalid = 1'b1;
      nxt_s.rsp.bresp = dtp_pkg::RESP_OKAY;
      case (s_ff.widx)
        dtp_pkg::IDX_RUN: begin
          if (s_ff.wlane) begin
            nxt_s.run_lower = s_ff.wbyte[dtp_pkg::RUN_LOWER_BIT];   // [RL23]
            nxt_s.run_upper = s_ff.wbyte[dtp_pkg::RUN_UPPER_BIT];
          end
        end
        dtp_pkg::IDX_TOGGLE: begin
          if (s_ff.wlane) begin
            nxt_s.tog_sel = s_ff.wbyte[dtp_pkg::TOG_SEL_BIT];
            nxt_s.tog_en = s_ff.wbyte[dtp_pkg::TOG_EN_BIT];
            case (s_ff.wbyte[dtp_pkg::TOG_CMD_LSB +: 2])
              dtp_pkg::TCMD_INVERT: nxt_s.tff = !s_ff.tff;
              dtp_pkg::TCMD_CLEAR: nxt_s.tff = 1'b0;
              dtp_pkg::TCMD_SET: nxt_s.tff = 1'b1;
              default: nxt_s.tff = nxt_s.tff;
            endcase
          end
        end
        dtp_pkg::IDX_LCMP: begin
          if (s_ff.wlane) begin
            nxt_s.lbuf = s_ff.wbyte;                                // [RL24]
            if (!s_ff.buf_en) begin
              nxt_s.lcmp = s_ff.wbyte;
            end
            nxt_s.cmp_hold = 1'b1;                                  // [RL5]
          end
        end
        dtp_pkg::IDX_UCMP: begin
          if (s_ff.wlane) begin
            nxt_s.ucmp = s_ff.wbyte;
            nxt_s.cmp_hold = 1'b0;
          end
        end
        dtp_pkg::IDX_MODE: begin
          if (s_ff.wlane) begin
            nxt_s.mode_reg = s_ff.wbyte;
          end
        end
        dtp_pkg::IDX_BUF: begin
          if (s_ff.wlane) begin
            nxt_s.buf_en = s_ff.wbyte[dtp_pkg::BUF_EN_BIT];         // [RL17]
          end
        end
        dtp_pkg::IDX_STAT: nxt_s.rsp.bresp = dtp_pkg::RESP_OKAY;
        default: nxt_s.rsp.bresp = dtp_pkg::RESP_SLVERR;
      endcase
    end
    nxt_s.rsp.awready = !nxt_s.aw_got && !nxt_s.rsp.bvalid;
    nxt_s.rsp.wready = !nxt_s.w_got && !nxt_s.rsp.bvalid;
    // one read at a time: the answer is registered from the mux
    if (s_ff.rsp.rvalid && axi_req.rready) begin
      nxt_s.rsp.rvalid = 1'b0;
    end
    if (s_ff.rsp.arready && axi_req.arvalid) begin
      nxt_s.rsp.rvalid = 1'b1;
      nxt_s.rsp.rdata = rd_word;
      nxt_s.rsp.rresp = rd_ok ? dtp_pkg::RESP_OKAY : dtp_pkg::RESP_SLVERR;
    end
    nxt_s.rsp.arready = !nxt_s.rsp.rvalid;
  end

  // reset leaves every ready low for one cycle, so nothing is taken early
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff <= '0;                                                   // [RL23]
      s_ff.mode_reg <= dtp_pkg::MODE_RST;
      s_ff.lcmp <= dtp_pkg::CMP_RST;
      s_ff.ucmp <= dtp_pkg::CMP_RST;
      s_ff.lbuf <= dtp_pkg::CMP_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always_comb begin
    axi_rsp = s_ff.rsp;
    toggle_output_pin = s_ff.tff;                                   // [RL16]
    lower_match_irq = s_ff.irq_lower;
    upper_match_irq = s_ff.irq_upper;
  end

endmodule : dtp_timer_pair

// File: bench/dtp_timer_pair_monitor.sv
// port-level assertions for the dual 8-bit timer pair
// assumes: bound to dtp_timer_pair, master offers aw and w together
`timescale 1ns/10ps
module dtp_timer_pair_monitor (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire dtp_pkg::dtp_axi_req_s axi_req,
  input wire dtp_pkg::dtp_axi_rsp_s axi_rsp,
  // taps and outputs
  input wire dtp_pkg::dtp_taps_s taps,
  input wire logic toggle_output_pin,
  input wire logic lower_match_irq,
  input wire logic upper_match_irq
);
  // ----
  // shadow of mode and run bits, taken at the bus handshake
  // ----
  logic wr;
  logic [7:0] mode_ff;
  logic [7:0] nxt_mode;
  logic [1:0] run_ff;
  logic [1:0] nxt_run;
  assign wr = axi_req.awvalid && axi_rsp.awready && axi_req.wvalid &&
    axi_rsp.wready;
  always_comb begin
    nxt_mode = mode_ff;
    nxt_run = run_ff;
    if (wr && axi_req.awaddr == 8'hA0) nxt_mode = axi_req.wdata[7:0];
    if (wr && axi_req.awaddr == 8'h80) nxt_run = axi_req.wdata[3:2];
  end
  always_ff @(posedge aclk) begin
    mode_ff <= aresetn ? nxt_mode : 8'h00;
    run_ff <= aresetn ? nxt_run : 2'b00;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----
  // properties; three-cycle history hides events still in flight
  // ----
  property p_rst;
    $rose(aresetn) |-> !toggle_output_pin && !lower_match_irq &&
      !upper_match_irq && !axi_rsp.awready ##1 axi_rsp.arready;
  endproperty
  a_rst: assert property (p_rst)
    else $error("outputs not idle after reset");
  property p_cas_low;
    mode_ff[7:6] == 2'b01 && $past(mode_ff[7:6], 3) == 2'b01
      |-> !lower_match_irq;
  endproperty
  a_cas_low: assert property (p_cas_low)
    else $error("lower interrupt in cascaded mode");
  property p_stop_lo;
    !run_ff[0] && !$past(run_ff[0], 3) |-> !lower_match_irq;
  endproperty
  a_stop_lo: assert property (p_stop_lo)
    else $error("lower interrupt while stopped");
  property p_stop_up;
    !run_ff[1] && !$past(run_ff[1], 3) |-> !upper_match_irq;
  endproperty
  a_stop_up: assert property (p_stop_up)
    else $error("upper interrupt while stopped");
  property p_tog_rd;
    axi_req.arvalid && axi_rsp.arready && axi_req.araddr == 8'h90
      |=> axi_rsp.rvalid && axi_rsp.rdata[1:0] == 2'b11;
  endproperty
  a_tog_rd: assert property (p_tog_rd)
    else $error("toggle command field not read as ones");
  property p_buf_rd;
    axi_req.arvalid && axi_rsp.arready && axi_req.araddr == 8'hA4
      |=> axi_rsp.rvalid && !axi_rsp.rdata[0];
  endproperty
  a_buf_rd: assert property (p_buf_rd)
    else $error("buffer control bit0 not zero");
  property p_mode_rd;
    axi_req.arvalid && axi_rsp.arready && axi_req.araddr == 8'hA0
      |=> axi_rsp.rdata[7:0] == mode_ff;
  endproperty
  a_mode_rd: assert property (p_mode_rd)
    else $error("mode readback differs");
  property p_bresp;
    wr |=> !axi_rsp.bvalid ##1 axi_rsp.bvalid;
  endproperty
  a_bresp: assert property (p_bresp)
    else $error("write response late");
  property p_pin;
    $changed(toggle_output_pin) |-> run_ff != 2'b00 ||
      $past(run_ff) != 2'b00 || $past(wr, 2);
  endproperty
  a_pin: assert property (p_pin)
    else $error("pin moved with timers stopped");
  c_two8: cover property (lower_match_irq && mode_ff[7:6] == 2'b00);
  c_cas: cover property (upper_match_irq && mode_ff[7:6] == 2'b01);
  c_pwm: cover property ($rose(toggle_output_pin) && mode_ff[7:6] == 2'b11);
endmodule : dtp_timer_pair_monitor

bind dtp_timer_pair dtp_timer_pair_monitor dtp_timer_pair_monitor_i (
  .aclk(aclk),
  .aresetn(aresetn),
  .axi_req(axi_req),
  .axi_rsp(axi_rsp),
  .taps(taps),
  .toggle_output_pin(toggle_output_pin),
  .lower_match_irq(lower_match_irq),
  .upper_match_irq(upper_match_irq)
);

// File: bench/dtp_timer_pair_tb_top.sv
// self-checking bench for the dual 8-bit timer pair
// assumes: fine tap every cycle, so one lower tick per clock
`timescale 1ns/10ps
module dtp_timer_pair_tb_top;
  localparam logic [7:0] A_RUN = {dtp_pkg::IDX_RUN, 2'b00};
  localparam logic [7:0] A_TOG = {dtp_pkg::IDX_TOGGLE, 2'b00};
  localparam logic [7:0] A_LC = {dtp_pkg::IDX_LCMP, 2'b00};
  localparam logic [7:0] A_UC = {dtp_pkg::IDX_UCMP, 2'b00};
  localparam logic [7:0] A_MODE = {dtp_pkg::IDX_MODE, 2'b00};
  localparam logic [7:0] A_BUF = {dtp_pkg::IDX_BUF, 2'b00};
  localparam logic [7:0] A_STAT = {dtp_pkg::IDX_STAT, 2'b00};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  dtp_pkg::dtp_axi_req_s rq = '0;
  dtp_pkg::dtp_axi_rsp_s rs;
  dtp_pkg::dtp_taps_s tp = '0;
  logic pin, li, ui;
  logic [7:0] pc = 8'h00;
  logic [31:0] d;
  int n;
  int err_count = 0;
  int total_checks = 0;
  always #50 aclk = ~aclk;
  // ----
  // prescaler taps: divide by 1, 4, 16 and 256
  // ----
  always @(posedge aclk) begin
    pc <= pc + 8'h01;
    tp.fine <= 1'b1;
    tp.quarter <= pc[1:0] == 2'b11;
    tp.sixteenth <= pc[3:0] == 4'hF;
    tp.coarse <= pc == 8'hFF;
  end
  dtp_timer_pair dtp_timer_pair_i (
    .aclk(aclk),
    .aresetn(aresetn),
    .axi_req(rq),
    .axi_rsp(rs),
    .taps(tp),
    .toggle_output_pin(pin),
    .lower_match_irq(li),
    .upper_match_irq(ui)
  );
  // ----
  // shared tasks
  // ----
  task automatic end_of_test();
    $display("errors %0d checks %0d", err_count, total_checks);
    if (err_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
      input logic [1:0] e = 2'b00);
    int i;
    @(posedge aclk);
    rq.awaddr <= a;
    rq.wdata <= v;
    rq.wstrb <= 4'hF;
    rq.awvalid <= 1'b1;
    rq.wvalid <= 1'b1;
    rq.bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (rs.awready && rq.awvalid) rq.awvalid <= 1'b0;
      if (rs.wready && rq.wvalid) rq.wvalid <= 1'b0;
      if (rs.bvalid === 1'b1) break;
    end
    rq.bready <= 1'b0;
    chk(rs.bresp, e);
    if (i == 50) begin
      err_count++;
      end_of_test();
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v,
      input logic [1:0] e = 2'b00);
    int i;
    @(posedge aclk);
    rq.araddr <= a;
    rq.arvalid <= 1'b1;
    rq.rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (rs.arready && rq.arvalid) rq.arvalid <= 1'b0;
      if (rs.rvalid === 1'b1) break;
    end
    v = rs.rdata;
    rq.rready <= 1'b0;
    chk(rs.rresp, e);
    if (i == 50) begin
      err_count++;
      end_of_test();
    end
  endtask : rd
  // events: 0 lower irq, 1 upper irq, 2 pin rise, 3 pin fall
  function automatic logic hit(input int w, input logic p);
    case (w)
      0: return li;
      1: return ui;
      2: return pin && !p;
      default: return !pin && p;
    endcase
  endfunction : hit
  // cycles from one event to the next; bounded so a dead timer fails
  task automatic per(input int ws, input int we, output int k);
    int i;
    logic p, h;
    p = pin;
    for (i = 0; i < 2; i++) begin
      k = 0;
      do begin
        @(posedge aclk);
        k++;
        h = hit(i == 0 ? ws : we, p);
        p = pin;
      end while (h !== 1'b1 && k < 2000);
      if (h !== 1'b1) begin
        err_count++;
        end_of_test();
      end
    end
  endtask : per
  // ----
  // scenarios
  // ----
  task automatic s_regs();
    rd(A_MODE, d);
    chk(d[7:0], 8'h00);
    rd(A_BUF, d);
    chk(d[7:0], 8'h00);
    wr(A_TOG, 32'h0000_0008);
    rd(A_TOG, d);
    chk(d[3:0], 4'hB);
    wr(A_BUF, 32'h0000_0003);
    rd(A_BUF, d);
    chk(d[1:0], 2'b10);
    wr(A_BUF, 32'h0000_0000);
    rd(8'hFC, d, dtp_pkg::RESP_SLVERR);
    wr(8'hFC, 32'h0000_0001, dtp_pkg::RESP_SLVERR);
  endtask : s_regs
  task automatic s_interval();
    wr(A_MODE, 32'h0000_0001);
    wr(A_LC, 32'h0000_0005);
    wr(A_UC, 32'h0000_0003);
    wr(A_RUN, 32'h0000_000C);
    per(0, 0, n);
    chk(n, 5);
    per(1, 1, n);
    chk(n, 15);
    wr(A_LC, 32'h0000_0000);
    per(0, 0, n);
    chk(n, 256);
    wr(A_RUN, 32'h0000_0000);
    rd(A_STAT, d);
    chk(d[15:0], 16'h0000);
    wr(A_MODE, 32'h0000_0002);
    wr(A_LC, 32'h0000_0005);
    wr(A_RUN, 32'h0000_0004);
    per(0, 0, n);
    chk(n, 20);
    wr(A_RUN, 32'h0000_0000);
  endtask : s_interval
  task automatic s_cascade();
    wr(A_MODE, 32'h0000_004D);
    wr(A_LC, 32'h0000_0002);
    rd(A_STAT, d);
    chk(d[17], 1'b1);
    wr(A_UC, 32'h0000_0001);
    rd(A_STAT, d);
    chk(d[17], 1'b0);
    wr(A_RUN, 32'h0000_000C);
    per(1, 1, n);
    chk(n, 258);
    wr(A_RUN, 32'h0000_0000);
  endtask : s_cascade
  task automatic s_pwm();
    int c;
    for (c = 1; c < 4; c++) begin
      wr(A_RUN, 32'h0000_0000);
      wr(A_MODE, 32'h0000_00C5 | (c << 4));
      wr(A_LC, 32'h0000_0010);
      wr(A_TOG, 32'h0000_0009);
      wr(A_RUN, 32'h0000_0004);
      per(0, 0, n);
      chk(n, (64 << (c - 1)) - 1);
      per(2, 3, n);
      chk(n, (64 << (c - 1)) - 17);
    end
    wr(A_UC, 32'h0000_0009);
    wr(A_RUN, 32'h0000_000C);
    per(1, 1, n);
    chk(n, 9);
    wr(A_BUF, 32'h0000_0002);
    wr(A_LC, 32'h0000_0040);
    per(0, 0, n);
    per(2, 3, n);
    chk(n, 191);
    wr(A_BUF, 32'h0000_0000);
  endtask : s_pwm
  task automatic s_ppg();
    wr(A_RUN, 32'h0000_0000);
    wr(A_MODE, 32'h0000_0081);
    wr(A_LC, 32'h0000_0003);
    wr(A_UC, 32'h0000_0008);
    wr(A_TOG, 32'h0000_0009);
    wr(A_RUN, 32'h0000_000C);
    per(2, 2, n);
    chk(n, 8);
    per(2, 3, n);
    chk(n, 5);
    wr(A_BUF, 32'h0000_0002);
    wr(A_LC, 32'h0000_0005);
    per(2, 2, n);
    per(2, 3, n);
    chk(n, 3);
    wr(A_RUN, 32'h0000_0000);
  endtask : s_ppg
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    s_regs();
    s_interval();
    s_cascade();
    s_pwm();
    s_ppg();
    end_of_test();
  end
endmodule : dtp_timer_pair_tb_top
